// ==== smpg_map.svh ====
// register offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SMPG_MAP_SVH
`define SMPG_MAP_SVH
`define SMPG_OFF_SLEEP_CTRL      12'h000
`define SMPG_OFF_POWER_GATE      12'h004
`define SMPG_OFF_SLEEP_CFG       12'h008
`define SMPG_OFF_STATUS          12'h00C
`define SMPG_SE_BIT              0
`define SMPG_SM_LSB              1
`define SMPG_SM_MSB              3
`define SMPG_RST_SLEEP_CTRL      4'h0
`define SMPG_RST_POWER_GATE      7'h00
`define SMPG_RST_SLEEP_CFG       16'h0010
`define SMPG_CFG_STARTUP_LSB     0
`define SMPG_CFG_STARTUP_MSB     15
`define SMPG_HALT_CYCLES         3'h4
`define SMPG_STANDBY_CYCLES      16'h0006
`define SMPG_NUM_PERIPH          7
`define SMPG_ADC_BIT             0
`endif

// ==== smpg_pkg.sv ====
// types shared by the sleep and power-gating controller
package smpg_pkg;
	typedef enum logic [2:0] {
		SMPG_MODE_IDLE    = 3'h0,
		SMPG_MODE_NOISE   = 3'h1,
		SMPG_MODE_PDOWN   = 3'h2,
		SMPG_MODE_STANDBY = 3'h6
	} smpg_mode_t;
	typedef enum {SMPG_ST_RUN, SMPG_ST_SLEEP, SMPG_ST_WAKE, SMPG_ST_HALT} smpg_state_t;
endpackage

// ==== smpg_ctrl.sv ====
// sleep-mode and peripheral clock-gating controller with apb register access
// Notes on behaviour
// - sleep only when enable set and instruction executed
// - wake halts core four cycles past startup
// - wake never touches register file or memory
// - reset during sleep restarts at reset vector
// - mode 000 idle stops core, program clocks
// - idle wakes on any enabled interrupt
// - converter starts conversion entering idle or noise
// - mode 001 stops io, core, program clocks
// - noise mode limited wake source set
// - mode 010 power-down stops all generated clocks
// - power-down wakes on reset, stage, level irq
// - power-down wake waits fuse startup delay
// - mode 110 crystal standby, six-cycle wake
// - gate bit stops clock, blocks register access
// - clearing gate bit resumes frozen peripheral
// - per-module gating matters in active, idle
// - enabled converter stays enabled while asleep
// - comparator off in deep modes unless reference
// - watchdog and brownout run in all modes
// - input buffers off when io, converter stopped
// - control reg: mode bits 3:1, enable bit 0
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "smpg_map.svh"
module smpg_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_instr,
	input  wire logic        irq_any,
	input  wire logic        irq_converter_done,
	input  wire logic        irq_timer,
	input  wire logic        irq_self_program_ready,
	input  wire logic        irq_power_stage_ctrl,
	input  wire logic [3:0]  external_irq_lines,
	input  wire logic        reset_request,
	input  wire logic        crystal_selected,
	input  wire logic        converter_enabled,
	input  wire logic        comparator_uses_ref,
	input  wire logic        watchdog_enabled,
	input  wire logic        brownout_enabled,
	output logic             core_clock_en,
	output logic             program_memory_clock_en,
	output logic             peripheral_io_clock_en,
	output logic             converter_clock_en,
	output logic             fast_pll_clock_en,
	output logic             oscillator_en,
	output logic [6:0]       periph_clock_en,
	output logic [6:0]       periph_access_en,
	output logic             converter_start,
	output logic             converter_keep_on,
	output logic             comparator_force_off,
	output logic             watchdog_keep_on,
	output logic             brownout_keep_on,
	output logic             input_buffers_off,
	output logic             core_halted,
	output logic             core_restart_vector,
	output logic             core_service_irq
);
	logic [3:0]               sleep_control_reg;
	logic [6:0]               power_gate_reg;
	logic [15:0]              startup_cycles;
	smpg_pkg::smpg_state_t    state;
	smpg_pkg::smpg_mode_t     mode;
	logic [15:0]              wait_cnt;
	logic [2:0]               halt_cnt;
	logic                     wake_src;
	logic                     mode_valid;
	logic                     apb_access;
	logic                     sleep_entry;
	logic                     asleep_idle;
	logic                     gate_io;
	logic                     gate_conv;
	logic                     gate_osc;
	logic [31:0]              next_prdata;
	logic                     next_slverr;

	assign apb_access = psel && penable;
	assign mode_valid = (sleep_control_reg[`SMPG_SM_MSB:`SMPG_SM_LSB] == 3'h0)
		|| (sleep_control_reg[`SMPG_SM_MSB:`SMPG_SM_LSB] == 3'h1)
		|| (sleep_control_reg[`SMPG_SM_MSB:`SMPG_SM_LSB] == 3'h2)
		|| (sleep_control_reg[`SMPG_SM_MSB:`SMPG_SM_LSB] == 3'h6 && crystal_selected);
	assign sleep_entry = (state == smpg_pkg::SMPG_ST_RUN) && sleep_instr
		&& sleep_control_reg[`SMPG_SE_BIT] && mode_valid;

	// wake source per mode; level interrupts only outside idle
	always_comb
	begin
		case (mode)
			smpg_pkg::SMPG_MODE_IDLE:  wake_src = irq_any;
			smpg_pkg::SMPG_MODE_NOISE: wake_src = irq_converter_done || irq_timer
				|| irq_self_program_ready || (|external_irq_lines);
			smpg_pkg::SMPG_MODE_PDOWN, smpg_pkg::SMPG_MODE_STANDBY:
				wake_src = irq_power_stage_ctrl || (|external_irq_lines);
			default: wake_src = 1'b0;
		endcase
	end

	// apb register file, zero wait states
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		case (paddr)
			`SMPG_OFF_SLEEP_CTRL: next_prdata = {28'h0000000, sleep_control_reg};
			`SMPG_OFF_POWER_GATE: next_prdata = {25'h0000000, power_gate_reg};
			`SMPG_OFF_SLEEP_CFG:  next_prdata = {16'h0000, startup_cycles};
			`SMPG_OFF_STATUS:     next_prdata = {29'h0000000, core_halted, mode_valid,
				state == smpg_pkg::SMPG_ST_SLEEP};
			default:              next_slverr = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
			pslverr <= psel && !penable && next_slverr;
		end
	end

	// writes take effect at the access edge, pready is high then
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_control_reg <= `SMPG_RST_SLEEP_CTRL;
			power_gate_reg    <= `SMPG_RST_POWER_GATE;
			startup_cycles    <= `SMPG_RST_SLEEP_CFG;
		end
		else if (apb_access && pready && pwrite)
		begin
			case (paddr)
				`SMPG_OFF_SLEEP_CTRL: sleep_control_reg <= pwdata[3:0];
				`SMPG_OFF_POWER_GATE: power_gate_reg <= pwdata[6:0];
				`SMPG_OFF_SLEEP_CFG:  startup_cycles <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
				default: ;
			endcase
		end
	end

	// sleep sequencer; register file and memory are never reset here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state    <= smpg_pkg::SMPG_ST_RUN;
			mode     <= smpg_pkg::SMPG_MODE_IDLE;
			wait_cnt <= 16'h0000;
			halt_cnt <= 3'h0;
		end
		else
		begin
			case (state)
				smpg_pkg::SMPG_ST_RUN:
					if (sleep_entry)
					begin
						state <= smpg_pkg::SMPG_ST_SLEEP;
						mode  <= smpg_pkg::smpg_mode_t'(sleep_control_reg[`SMPG_SM_MSB:`SMPG_SM_LSB]);
					end
				smpg_pkg::SMPG_ST_SLEEP:
					if (reset_request)
						state <= smpg_pkg::SMPG_ST_RUN;
					else if (wake_src)
					begin
						state <= smpg_pkg::SMPG_ST_WAKE;
						case (mode)
							smpg_pkg::SMPG_MODE_PDOWN:   wait_cnt <= startup_cycles;
							smpg_pkg::SMPG_MODE_STANDBY: wait_cnt <= `SMPG_STANDBY_CYCLES;
							default:                     wait_cnt <= 16'h0001;
						endcase
					end
				smpg_pkg::SMPG_ST_WAKE:
					if (reset_request)
						state <= smpg_pkg::SMPG_ST_RUN;
					else if (wait_cnt <= 16'h0001)
					begin
						state    <= smpg_pkg::SMPG_ST_HALT;
						halt_cnt <= `SMPG_HALT_CYCLES;
					end
					else
						wait_cnt <= wait_cnt - 16'h0001;
				smpg_pkg::SMPG_ST_HALT:
					if (reset_request || halt_cnt == 3'h1)
						state <= smpg_pkg::SMPG_ST_RUN;
					else
						halt_cnt <= halt_cnt - 3'h1;
				default: state <= smpg_pkg::SMPG_ST_RUN;
			endcase
		end
	end

	assign asleep_idle = (state == smpg_pkg::SMPG_ST_SLEEP) && (mode == smpg_pkg::SMPG_MODE_IDLE);
	assign gate_io     = (state == smpg_pkg::SMPG_ST_SLEEP) && (mode != smpg_pkg::SMPG_MODE_IDLE);
	assign gate_conv   = (state == smpg_pkg::SMPG_ST_SLEEP)
		&& (mode == smpg_pkg::SMPG_MODE_PDOWN || mode == smpg_pkg::SMPG_MODE_STANDBY);
	assign gate_osc    = (state == smpg_pkg::SMPG_ST_SLEEP) && (mode == smpg_pkg::SMPG_MODE_PDOWN);

	// clock enables for the domains, registered for glitch-free gating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_clock_en           <= 1'b1;
			program_memory_clock_en <= 1'b1;
			peripheral_io_clock_en  <= 1'b1;
			converter_clock_en      <= 1'b1;
			fast_pll_clock_en       <= 1'b1;
			oscillator_en           <= 1'b1;
			input_buffers_off       <= 1'b0;
			comparator_force_off    <= 1'b0;
		end
		else
		begin
			core_clock_en           <= !(sleep_entry || state == smpg_pkg::SMPG_ST_SLEEP);
			program_memory_clock_en <= !(sleep_entry || state == smpg_pkg::SMPG_ST_SLEEP);
			peripheral_io_clock_en  <= !gate_io;
			converter_clock_en      <= !gate_conv;
			fast_pll_clock_en       <= !gate_conv;
			oscillator_en           <= !gate_osc;
			input_buffers_off       <= gate_io && gate_conv;
			comparator_force_off    <= gate_conv && !comparator_uses_ref;
		end
	end

	// per-peripheral gating; deep sleep stops all of them anyway
	genvar gi;
	generate
		for (gi = 0; gi < `SMPG_NUM_PERIPH; gi++)
		begin : g_periph
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					periph_clock_en[gi]  <= 1'b1;
					periph_access_en[gi] <= 1'b1;
				end
				else
				begin
					periph_clock_en[gi]  <= !power_gate_reg[gi] && !gate_io;
					periph_access_en[gi] <= !power_gate_reg[gi];
				end
			end
		end
	endgenerate

	// always-on helpers and core handshake
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			converter_start     <= 1'b0;
			converter_keep_on   <= 1'b0;
			watchdog_keep_on    <= 1'b0;
			brownout_keep_on    <= 1'b0;
			core_halted         <= 1'b0;
			core_restart_vector <= 1'b0;
			core_service_irq    <= 1'b0;
		end
		else
		begin
			converter_start <= sleep_entry && converter_enabled
				&& !power_gate_reg[`SMPG_ADC_BIT]
				&& sleep_control_reg[`SMPG_SM_MSB:`SMPG_SM_LSB + 1] == 2'h0;
			converter_keep_on   <= converter_enabled;
			watchdog_keep_on    <= watchdog_enabled;
			brownout_keep_on    <= brownout_enabled;
			core_halted         <= sleep_entry || (state != smpg_pkg::SMPG_ST_RUN
				&& !(state == smpg_pkg::SMPG_ST_HALT && halt_cnt == 3'h1));
			core_restart_vector <= state != smpg_pkg::SMPG_ST_RUN && reset_request;
			core_service_irq    <= state == smpg_pkg::SMPG_ST_HALT && halt_cnt == 3'h1
				&& !reset_request;
		end
	end

	AST_NO_SLEEP_WITHOUT_SE: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_RUN && sleep_instr && !sleep_control_reg[0])
			|=> state == smpg_pkg::SMPG_ST_RUN)
		else $error("sleep entered with enable clear");
	AST_HALT_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_WAKE && $past(state) == smpg_pkg::SMPG_ST_WAKE
			&& wait_cnt <= 16'h0001 && !reset_request)
			##1 !reset_request [*4] |=> core_service_irq)
		else $error("interrupt not serviced four cycles after startup");
	AST_RESET_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && reset_request) |=> core_restart_vector)
		else $error("reset during sleep not restarting");
	AST_IDLE_CLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
		asleep_idle |=> (!core_clock_en && peripheral_io_clock_en && converter_clock_en))
		else $error("idle clock gating wrong");
	AST_NOISE_CLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && mode == smpg_pkg::SMPG_MODE_NOISE)
			|=> (!peripheral_io_clock_en && converter_clock_en))
		else $error("noise mode clock gating wrong");
	AST_PDOWN_NO_TIMER_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && mode == smpg_pkg::SMPG_MODE_PDOWN && !reset_request
			&& !irq_power_stage_ctrl && external_irq_lines == 4'h0) |=> state == smpg_pkg::SMPG_ST_SLEEP)
		else $error("power-down woke from illegal source");
	AST_STANDBY_SIX: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(state == smpg_pkg::SMPG_ST_WAKE) && mode == smpg_pkg::SMPG_MODE_STANDBY
			&& oscillator_en) ##1 !reset_request [*5] |=> state == smpg_pkg::SMPG_ST_HALT)
		else $error("standby wake not six cycles");
	AST_GATE_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
		power_gate_reg[1] |=> !periph_access_en[1] && !periph_clock_en[1])
		else $error("gated peripheral still clocked");
	AST_BUFFERS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		gate_conv |=> input_buffers_off)
		else $error("input buffers left on");
	AST_RESERVED_MODE: assert property (@(posedge pclk) disable iff (!presetn)
		(sleep_instr && !mode_valid && state == smpg_pkg::SMPG_ST_RUN) |=> core_clock_en)
		else $error("reserved mode gated clocks");
	COV_IDLE_WAKE: cover property (@(posedge pclk) disable iff (!presetn)
		asleep_idle ##1 state == smpg_pkg::SMPG_ST_WAKE);
	COV_PDOWN_WAKE: cover property (@(posedge pclk) disable iff (!presetn)
		gate_osc ##1 state == smpg_pkg::SMPG_ST_WAKE);
	COV_SERVICE: cover property (@(posedge pclk) disable iff (!presetn) core_service_irq);
	COV_RESET_WAKE: cover property (@(posedge pclk) disable iff (!presetn) core_restart_vector);
	COV_STANDBY_WAKE: cover property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && mode == smpg_pkg::SMPG_MODE_STANDBY) ##1 state == smpg_pkg::SMPG_ST_WAKE);

	// per-mode gating, helpers, wake sources and register hold, one cycle after the sampled state except the service-clock check
	AST_STANDBY_OSC_ON: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && mode == smpg_pkg::SMPG_MODE_STANDBY) |=> oscillator_en)
		else $error("standby stopped the oscillator");
	AST_PDOWN_CLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && mode == smpg_pkg::SMPG_MODE_PDOWN)
			|=> (!oscillator_en && !converter_clock_en && !fast_pll_clock_en))
		else $error("power-down left a clock running");
	AST_COMP_REF: assert property (@(posedge pclk) disable iff (!presetn)
		(gate_conv && comparator_uses_ref) |=> !comparator_force_off)
		else $error("comparator forced off while using reference");
	AST_KEEP_ON: assert property (@(posedge pclk) disable iff (!presetn)
		(converter_enabled && watchdog_enabled && brownout_enabled)
			|=> (converter_keep_on && watchdog_keep_on && brownout_keep_on))
		else $error("always-on helper dropped");
	AST_CONV_NO_DEEP: assert property (@(posedge pclk) disable iff (!presetn)
		(sleep_entry && sleep_control_reg[3:2] != 2'h0) |=> !converter_start)
		else $error("conversion started entering deep sleep");
	AST_SERVICE_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
		core_service_irq |-> core_clock_en)
		else $error("interrupt serviced with core clock stopped");
	AST_PERIPH_DEEP: assert property (@(posedge pclk) disable iff (!presetn)
		gate_io |=> periph_clock_en == 7'h00)
		else $error("peripheral clock running in deep sleep");
	AST_RESERVED_NO_HALT: assert property (@(posedge pclk) disable iff (!presetn)
		(sleep_instr && !mode_valid && state == smpg_pkg::SMPG_ST_RUN) |=> !core_halted)
		else $error("reserved mode halted the core");
	AST_NOISE_SOURCES: assert property (@(posedge pclk) disable iff (!presetn)
		(state == smpg_pkg::SMPG_ST_SLEEP && mode == smpg_pkg::SMPG_MODE_NOISE && !reset_request && !irq_converter_done
			&& !irq_timer && !irq_self_program_ready && external_irq_lines == 4'h0) |=> state == smpg_pkg::SMPG_ST_SLEEP)
		else $error("noise mode woke from illegal source");
	AST_IDLE_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep_idle && irq_any && !reset_request) |=> state == smpg_pkg::SMPG_ST_WAKE)
		else $error("idle did not wake on interrupt");
	AST_CTRL_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
		(state != smpg_pkg::SMPG_ST_RUN && !(apb_access && pwrite)) |=> $stable(sleep_control_reg))
		else $error("sleep control changed across wake");
endmodule // smpg_ctrl

// ==== smpg_wake_src.sv ====
// wake-source model: raises one requested request line and holds it until the core is serviced
`timescale 1ns/1ns
module smpg_wake_src (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       fire,
	input  wire logic [3:0] pick,
	input  wire logic       core_service_irq,
	output logic      [8:0] lines
);
	// the level is kept until service, so a slow start-up still sees the request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lines <= 9'h000;
		else if (core_service_irq)
			lines <= 9'h000;
		else if (fire)
			lines[pick] <= 1'b1;
	end
endmodule // smpg_wake_src

// ==== sleep_mode_power_gating_test.sv ====
// self-checking bench for the sleep and power-gating controller
`timescale 1ns/1ns
`include "smpg_map.svh"
module sleep_mode_power_gating_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_instr, reset_request, fire;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pick;
	logic [8:0]  lines;
	logic        crystal_selected, converter_enabled, comparator_uses_ref, watchdog_enabled, brownout_enabled;
	logic        core_clock_en, program_memory_clock_en, peripheral_io_clock_en, converter_clock_en;
	logic        fast_pll_clock_en, oscillator_en, converter_start, converter_keep_on, comparator_force_off;
	logic        watchdog_keep_on, brownout_keep_on, input_buffers_off, core_halted, core_restart_vector;
	logic        core_service_irq;
	logic [6:0]  periph_clock_en, periph_access_en;
	int          fail_count, total_checks, starts;

	smpg_ctrl u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
		.irq_any(lines[0]), .irq_converter_done(lines[1]), .irq_timer(lines[2]), .irq_self_program_ready(lines[3]),
		.irq_power_stage_ctrl(lines[4]), .external_irq_lines(lines[8:5]), .reset_request, .crystal_selected,
		.converter_enabled, .comparator_uses_ref, .watchdog_enabled, .brownout_enabled, .core_clock_en,
		.program_memory_clock_en, .peripheral_io_clock_en, .converter_clock_en, .fast_pll_clock_en, .oscillator_en,
		.periph_clock_en, .periph_access_en, .converter_start, .converter_keep_on, .comparator_force_off,
		.watchdog_keep_on, .brownout_keep_on, .input_buffers_off, .core_halted, .core_restart_vector,
		.core_service_irq);

	smpg_wake_src u_src (.pclk, .presetn, .fire, .pick, .core_service_irq, .lines);

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk)
		if (converter_start === 1'b1)
			starts <= starts + 1;

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// request held until pready is sampled high, then released with one idle edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic err);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (!wr)
			check(prdata, exp);
		check({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic do_sleep(input logic [31:0] ctrl);
		apb(1'b1, `SMPG_OFF_SLEEP_CTRL, ctrl, 32'h0, 1'b0);
		sleep_instr <= 1'b1;
		@(posedge pclk);
		sleep_instr <= 1'b0;
		tick(2);
	endtask

	task automatic raise(input logic [3:0] p);
		fire <= 1'b1;
		pick <= p;
		@(posedge pclk);
		fire <= 1'b0;
		@(posedge pclk);
	endtask

	// the wait covers start-up plus the four halt cycles, with slack for registered paths
	task automatic wake(input logic [3:0] p, input int w);
		int n;
		raise(p);
		n = 0;
		while (core_service_irq !== 1'b1 && n < 300)
		begin
			@(posedge pclk);
			n++;
		end
		chk1(n >= w + 2 && n <= w + 8, 1'b1);
		tick(2);
		chk1(core_clock_en, 1'b1);
	endtask

	task automatic t_regs;
		apb(1'b0, `SMPG_OFF_SLEEP_CTRL, 32'h0, 32'h0, 1'b0);
		apb(1'b0, `SMPG_OFF_POWER_GATE, 32'h0, 32'h0, 1'b0);
		apb(1'b0, `SMPG_OFF_SLEEP_CFG, 32'h0, 32'h10, 1'b0);
		apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
		apb(1'b1, `SMPG_OFF_SLEEP_CTRL, 32'hFF, 32'h0, 1'b0);
		apb(1'b0, `SMPG_OFF_SLEEP_CTRL, 32'h0, 32'hF, 1'b0);
		$display("test regs done");
	endtask

	task automatic t_nosleep;
		logic [31:0] v[3] = '{32'h0, 32'h7, 32'hD};
		foreach (v[i])
		begin
			do_sleep(v[i]);
			chk1(core_clock_en, 1'b1);
		end
		$display("test nosleep done");
	endtask

	task automatic t_idle_noise;
		int s0;
		s0 = starts;
		do_sleep(32'h1);
		check(starts, s0 + 1);
		check({26'h0, core_clock_en, program_memory_clock_en, peripheral_io_clock_en, converter_clock_en,
			fast_pll_clock_en, oscillator_en}, 32'hF);
		wake(4'h0, 1);
		do_sleep(32'h3);
		check(starts, s0 + 2);
		check({26'h0, core_clock_en, program_memory_clock_en, peripheral_io_clock_en, converter_clock_en,
			fast_pll_clock_en, oscillator_en}, 32'h7);
		raise(4'h0);
		tick(10);
		chk1(core_halted, 1'b1);
		apb(1'b0, `SMPG_OFF_STATUS, 32'h0, 32'h7, 1'b0);
		wake(4'h2, 1);
		$display("test idle and noise done");
	endtask

	task automatic t_pdown;
		apb(1'b1, `SMPG_OFF_SLEEP_CFG, 32'h3, 32'h0, 1'b0);
		do_sleep(32'h5);
		check({26'h0, core_clock_en, program_memory_clock_en, peripheral_io_clock_en, converter_clock_en,
			fast_pll_clock_en, oscillator_en}, 32'h0);
		check({25'h0, periph_clock_en}, 32'h0);
		check({28'h0, input_buffers_off, comparator_force_off, watchdog_keep_on, brownout_keep_on}, 32'hF);
		chk1(converter_keep_on, 1'b1);
		raise(4'h2);
		tick(10);
		chk1(core_clock_en, 1'b0);
		wake(4'h5, 3);
		crystal_selected    <= 1'b1;
		comparator_uses_ref <= 1'b1;
		do_sleep(32'hD);
		check({29'h0, core_clock_en, oscillator_en, comparator_force_off}, 32'h2);
		wake(4'h4, 6);
		$display("test pdown and standby done");
	endtask

	task automatic t_reset_gate;
		do_sleep(32'h5);
		reset_request <= 1'b1;
		tick(2);
		chk1(core_restart_vector, 1'b1);
		reset_request <= 1'b0;
		tick(3);
		chk1(core_clock_en, 1'b1);
		// the peripherals are idle here, so gating them is safe
		apb(1'b1, `SMPG_OFF_POWER_GATE, 32'h43, 32'h0, 1'b0);
		apb(1'b0, `SMPG_OFF_POWER_GATE, 32'h0, 32'h43, 1'b0);
		check({18'h0, periph_clock_en, periph_access_en}, 32'h1E3C);
		apb(1'b1, `SMPG_OFF_POWER_GATE, 32'h0, 32'h0, 1'b0);
		tick(1);
		check({18'h0, periph_clock_en, periph_access_en}, 32'h3FFF);
		$display("test reset and gating done");
	endtask

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, sleep_instr, reset_request, fire, crystal_selected, comparator_uses_ref} = 8'h00;
		{converter_enabled, watchdog_enabled, brownout_enabled} = 3'h7;
		paddr = 12'h000;
		pwdata = 32'h0;
		pick = 4'h0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		t_regs;
		t_nosleep;
		t_idle_noise;
		t_pdown;
		t_reset_gate;
		stop_test;
	end

	initial
	begin
		tick(20000);
		fail_count++;
		stop_test;
	end
endmodule // sleep_mode_power_gating_test
